// File: rtl/instr_seq.v
// instruction length, cycle count and conditional branch sequencer
//
// Summary of operation
// - load immediate to working register: two bytes, two cycles
// - indirect store of accumulator to data memory: one byte, one cycle
// - swap accumulator and working register: one byte, one cycle
// - timer branch: jump if overflow flag set, clear flag, two cycles
// - decrement register, jump if result nonzero; two bytes, two cycles
// - branch when input buffer full flag is zero; two bytes, two cycles
// - branch when output buffer full flag is one; two bytes, two cycles
// - carry branches jump on carry one or zero; two bytes, two cycles
// - accumulator branches jump on zero or nonzero; two bytes, cycles two
// - test input branches jump on input high or low; two bytes, two cycles
`include "instr_seq_map.vh"

module instr_seq #(
	parameter MC_DIV = `MC_DIV_DEFAULT
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        nrst,
	// program memory
	output reg  [11:0] prog_addr,
	input  wire [7:0]  prog_data,
	// flags from the rest of the core
	input  wire        carry,
	input  wire        timer_overflow_flag,
	input  wire        input_buffer_full_flag,
	input  wire        output_buffer_full_flag,
	input  wire        second_test_input,
	input  wire        bank_select,
	// flag side effects
	output reg         timer_flag_clear,
	// internal data memory write port
	output reg         dmem_we,
	output reg  [7:0]  dmem_addr,
	output reg  [7:0]  dmem_wdata,
	// state visible to the core
	output reg  [7:0]  acc,
	output reg         opcode_fetch,
	output reg         machine_cycle
);

	localparam ST_FETCH   = 1'b0;
	localparam ST_OPERAND = 1'b1;

	reg         state;
	reg  [7:0]  opcode;
	reg  [7:0]  div_cnt;
	reg  [7:0]  work_reg [0:15];
	wire        mc_en;
	wire [4:0]  cls;
	wire [3:0]  reg_sel;
	wire [3:0]  opr_sel;
	wire [7:0]  reg_val;
	wire [7:0]  opr_val;
	wire [7:0]  dec_val;
	reg         take;
	wire        fetch_en;
	wire        operand_en;
	wire        store_en;
	wire        swap_en;
	wire [4:0]  held_cls;
	reg         wr_en;
	reg  [3:0]  wr_sel;
	reg  [7:0]  wr_data;
	integer     i;

	// true for the whole-byte conditional branch opcodes
	function is_branch;
		input [7:0] op;
		begin
			is_branch = (op >= `OP_BRANCH_TIMER) &&
				(op <= `OP_BRANCH_T_LOW);
		end
	endfunction

	// true for opcodes that carry a second byte
	function two_byte;
		input [7:0] op;
		begin
			two_byte = (op[7:3] == `CLS_LOAD_IMM_REG) ||
				(op[7:3] == `CLS_DEC_BRANCH_NZ) ||
				is_branch(op);
		end
	endfunction

	assign mc_en   = (div_cnt == MC_DIV[7:0] - 8'h01);
	assign cls     = prog_data[`OPC_CLASS_HI:`OPC_CLASS_LO];
	assign reg_sel = {bank_select, prog_data[`OPC_REG_HI:`OPC_REG_LO]};
	assign opr_sel = {bank_select, opcode[`OPC_REG_HI:`OPC_REG_LO]};
	assign reg_val = work_reg[reg_sel];
	assign opr_val = work_reg[opr_sel];
	assign dec_val = opr_val - 8'h01;

	// every state change waits for the machine cycle enable
	assign fetch_en   = mc_en && (state == ST_FETCH);
	assign operand_en = mc_en && (state == ST_OPERAND);
	assign held_cls   = opcode[`OPC_CLASS_HI:`OPC_CLASS_LO];
	assign store_en   = fetch_en && (cls == `CLS_STORE_INDIRECT);
	assign swap_en    = fetch_en && (cls == `CLS_SWAP_ACC_REG);

	// branch condition for the held opcode
	always @* begin
		take = 1'b0;
		if (opcode[7:3] == `CLS_DEC_BRANCH_NZ)
			take = (dec_val != 8'h00);
		else begin
			case (opcode)
			`OP_BRANCH_TIMER:     take = timer_overflow_flag;
			`OP_BRANCH_IBF_EMPTY: take = ~input_buffer_full_flag;
			`OP_BRANCH_OBF_FULL:  take = output_buffer_full_flag;
			`OP_BRANCH_CARRY_SET: take = carry;
			`OP_BRANCH_CARRY_CLR: take = ~carry;
			`OP_BRANCH_ACC_ZERO:  take = (acc == 8'h00);
			`OP_BRANCH_ACC_NZ:    take = (acc != 8'h00);
			`OP_BRANCH_T_HIGH:    take = second_test_input;
			`OP_BRANCH_T_LOW:     take = ~second_test_input;
			default:              take = 1'b0;
			endcase
		end
	end

	// machine cycle divider
	always @(posedge clk_sys) begin
		if (!nrst)
			div_cnt <= 8'h00;
		else if (mc_en)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end

	// fetch and operand sequencing, program counter
	always @(posedge clk_sys) begin
		if (!nrst) begin
			state     <= ST_FETCH;
			opcode    <= 8'h00;
			prog_addr <= `RESET_PC;
		end else if (fetch_en) begin
			opcode    <= prog_data;
			prog_addr <= prog_addr + 12'h001;
			if (two_byte(prog_data))
				state <= ST_OPERAND;
		end else if (operand_en) begin
			// second byte is consumed before the next opcode is taken
			state <= ST_FETCH;
			if (take)
				prog_addr <= {prog_addr[11:8], prog_data};
			else
				prog_addr <= prog_addr + 12'h001;
		end
	end

	// single write port into the working registers
	always @* begin
		wr_en   = 1'b0;
		wr_sel  = opr_sel;
		wr_data = prog_data;
		if (swap_en) begin
			wr_en   = 1'b1;
			wr_sel  = reg_sel;
			wr_data = acc;
		end else if (operand_en && held_cls == `CLS_LOAD_IMM_REG) begin
			wr_en   = 1'b1;
		end else if (operand_en && held_cls == `CLS_DEC_BRANCH_NZ) begin
			wr_en   = 1'b1;
			wr_data = dec_val;
		end
	end

	// both banks clear at reset
	always @(posedge clk_sys) begin
		if (!nrst) begin
			for (i = 0; i < 16; i = i + 1)
				work_reg[i] <= 8'h00;
		end else if (wr_en) begin
			work_reg[wr_sel] <= wr_data;
		end
	end

	// accumulator changes only through the swap
	always @(posedge clk_sys) begin
		if (!nrst)
			acc <= `RESET_ACC;
		else if (swap_en)
			acc <= reg_val;
	end

	// data memory write port: address from the register, data from acc
	always @(posedge clk_sys) begin
		if (!nrst) begin
			dmem_we    <= 1'b0;
			dmem_addr  <= 8'h00;
			dmem_wdata <= 8'h00;
		end else begin
			dmem_we <= store_en;
			if (store_en) begin
				dmem_addr  <= reg_val;
				dmem_wdata <= acc;
			end
		end
	end

	// registered status outputs, each one clock behind its enable
	always @(posedge clk_sys) begin
		if (!nrst) begin
			timer_flag_clear <= 1'b0;
			opcode_fetch     <= 1'b0;
			machine_cycle    <= 1'b0;
		end else begin
			timer_flag_clear <= 1'b0;
			// clear goes out whether or not the branch is taken
			if (operand_en && opcode == `OP_BRANCH_TIMER)
				timer_flag_clear <= 1'b1;
			opcode_fetch     <= fetch_en;
			machine_cycle    <= mc_en;
		end
	end

endmodule

// File: rtl/instr_seq_map.vh
// opcode encodings and sequencer constants for the instruction sequencer
`ifndef INSTR_SEQ_MAP_VH
`define INSTR_SEQ_MAP_VH

// opcode classes: upper five bits select the class, low three the register
`define OPC_CLASS_HI        7
`define OPC_CLASS_LO        3
`define OPC_REG_HI          2
`define OPC_REG_LO          0

// register forms (low three bits pick the working register)
`define CLS_LOAD_IMM_REG    5'h01
`define CLS_STORE_INDIRECT  5'h02
`define CLS_SWAP_ACC_REG    5'h03
`define CLS_DEC_BRANCH_NZ   5'h04

// whole-byte branch opcodes
`define OP_BRANCH_TIMER     8'h80
`define OP_BRANCH_IBF_EMPTY 8'h81
`define OP_BRANCH_OBF_FULL  8'h82
`define OP_BRANCH_CARRY_SET 8'h83
`define OP_BRANCH_CARRY_CLR 8'h84
`define OP_BRANCH_ACC_ZERO  8'h85
`define OP_BRANCH_ACC_NZ    8'h86
`define OP_BRANCH_T_HIGH    8'h87
`define OP_BRANCH_T_LOW     8'h88

// reset values
`define RESET_PC            12'h000
`define RESET_ACC           8'h00

// clocks per machine cycle
`define MC_DIV_DEFAULT      1

`endif

// File: testbench/instr_seq_monitor.sv
// checker for sequencer timing and branches
module instr_seq_monitor (
	// clock, reset, program address and inputs
	input wire        clk_sys,
	input wire        nrst,
	input wire [11:0] prog_addr,
	input wire [7:0]  prog_data,
	input wire        carry,
	// outputs
	input wire        timer_flag_clear,
	input wire [7:0]  acc,
	input wire        opcode_fetch,
	input wire        machine_cycle
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_op(o);
		opcode_fetch && acc == 8'h00 && $past(prog_data) == o;
	endsequence
	sequence s_two; !opcode_fetch ##1 opcode_fetch; endsequence
	property p_len;
		opcode_fetch && $past(prog_data) inside {[8'h80:8'h88]} |=> s_two;
	endproperty
	a_len: assert property (p_len) else $error("length");
	property p_mc; $past(nrst) |-> machine_cycle; endproperty
	a_mc: assert property (p_mc) else $error("cycle");
	property p_pc;
		opcode_fetch |-> prog_addr == $past(prog_addr) + 12'h001;
	endproperty
	a_pc: assert property (p_pc) else $error("second byte");
	property p_clr; s_op(8'h80) |=> timer_flag_clear; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_once;
		timer_flag_clear |-> $past(prog_data, 2) == 8'h80;
	endproperty
	a_once: assert property (p_once) else $error("stray clear");
	property p_jz;
		s_op(8'h85) |=> prog_addr == {$past(prog_addr[11:8]), $past(prog_data)};
	endproperty
	a_jz: assert property (p_jz) else $error("zero");
	property p_jnz;
		s_op(8'h86) |=> prog_addr == $past(prog_addr) + 12'h001;
	endproperty
	a_jnz: assert property (p_jnz) else $error("nonzero");
	property p_cy;
		s_op(8'h84) |=> prog_addr[7:0] == ($past(carry) ?
			$past(prog_addr[7:0]) + 8'h01 : $past(prog_data));
	endproperty
	a_cy: assert property (p_cy) else $error("carry");
endmodule
bind instr_seq instr_seq_monitor mon (.*);

// File: testbench/slave_mcu_instruction_timing_tb.sv
// random programs run against a reference model of the sequencer
`include "instr_seq_map.vh"
module slave_mcu_instruction_timing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg         clk_sys = 1'b0;
	reg         nrst = 1'b0;
	reg  [4:0]  fl = 5'h00;
	reg         bank = 1'b0;
	reg  [7:0]  mem [0:4095];
	reg  [31:0] s = 32'hD426;
	integer     failures = 0;
	integer     n_checks = 0;
	integer     i;
	integer     j;
	// reference model
	reg         chk = 1'b0;
	reg         m_ph;
	reg  [7:0]  m_op;
	reg  [11:0] m_pc;
	reg  [7:0]  m_acc;
	reg  [7:0]  m_reg [0:15];
	reg  [7:0]  m_t;
	reg  [3:0]  m_r;
	reg         m_tk;
	reg         e_clr;
	reg         e_we;
	reg         e_fetch;
	reg         e_mc;
	reg  [7:0]  e_addr;
	reg  [7:0]  e_wdata;
	wire [11:0] prog_addr;
	wire [7:0]  prog_data = mem[prog_addr];
	wire        timer_flag_clear;
	wire        dmem_we;
	wire [7:0]  dmem_addr;
	wire [7:0]  dmem_wdata;
	wire [7:0]  acc;
	wire        opcode_fetch;
	wire        machine_cycle;
	instr_seq DUT (
		.clk_sys(clk_sys), .nrst(nrst), .prog_addr(prog_addr),
		.prog_data(prog_data), .carry(fl[0]), .timer_overflow_flag(fl[1]),
		.input_buffer_full_flag(fl[2]), .output_buffer_full_flag(fl[3]),
		.second_test_input(fl[4]), .bank_select(bank),
		.timer_flag_clear(timer_flag_clear), .dmem_we(dmem_we),
		.dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .acc(acc),
		.opcode_fetch(opcode_fetch), .machine_cycle(machine_cycle)
	);
	always #50 clk_sys = ~clk_sys;
	function [31:0] xorshift(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xorshift = t ^ (t << 5);
		end
	endfunction
	function is_two(input [7:0] b);
		is_two = b[7:3] == `CLS_LOAD_IMM_REG ||
			b[7:3] == `CLS_DEC_BRANCH_NZ ||
			(b >= `OP_BRANCH_TIMER && b <= `OP_BRANCH_T_LOW);
	endfunction
	// branch condition from the flags driven and the model accumulator
	function cond(input [7:0] b);
		case (b)
		`OP_BRANCH_TIMER:     cond = fl[1];
		`OP_BRANCH_IBF_EMPTY: cond = !fl[2];
		`OP_BRANCH_OBF_FULL:  cond = fl[3];
		`OP_BRANCH_CARRY_SET: cond = fl[0];
		`OP_BRANCH_CARRY_CLR: cond = !fl[0];
		`OP_BRANCH_ACC_ZERO:  cond = m_acc == 8'h00;
		`OP_BRANCH_ACC_NZ:    cond = m_acc != 8'h00;
		`OP_BRANCH_T_HIGH:    cond = fl[4];
		`OP_BRANCH_T_LOW:     cond = !fl[4];
		default:              cond = 1'b0;
		endcase
	endfunction
	task cmp_addr(input [11:0] got, input [11:0] want);
		n_checks++;
		if (got !== want) begin
			failures++;
			$display("ERROR %0t %h %h", $time, got, want);
		end
	endtask
	task cmp_byte(input [7:0] got, input [7:0] want);
		n_checks++;
		if (got !== want) begin
			failures++;
			$display("ERROR %0t %h %h", $time, got, want);
		end
	endtask
	task cmp_bit(input got, input want);
		n_checks++;
		if (got !== want) begin
			failures++;
			$display("ERROR %0t %h %h", $time, got, want);
		end
	endtask
	task summarize;
		if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// outputs launched at the previous edge are checked, then the model steps
	always @(posedge clk_sys) begin
		if (chk) begin
			cmp_addr(prog_addr, m_pc);
			cmp_byte(acc, m_acc);
			cmp_bit(dmem_we, e_we);
			cmp_byte(dmem_addr, e_addr);
			cmp_byte(dmem_wdata, e_wdata);
			cmp_bit(timer_flag_clear, e_clr);
			cmp_bit(opcode_fetch, e_fetch);
			cmp_bit(machine_cycle, e_mc);
		end
		e_we = 1'b0;
		e_clr = 1'b0;
		e_fetch = 1'b0;
		if (!nrst) begin
			m_ph = 1'b0;
			m_pc = `RESET_PC;
			m_acc = `RESET_ACC;
			e_addr = 8'h00;
			e_wdata = 8'h00;
			e_mc = 1'b0;
			for (j = 0; j < 16; j++)
				m_reg[j] = 8'h00;
			chk = 1'b1;
		end else if (!m_ph) begin
			e_mc = 1'b1;
			m_op = mem[m_pc];
			m_r = {bank, m_op[2:0]};
			m_pc = m_pc + 12'h001;
			e_fetch = 1'b1;
			if (m_op[7:3] == `CLS_STORE_INDIRECT) begin
				e_we = 1'b1;
				e_addr = m_reg[m_r];
				e_wdata = m_acc;
			end
			if (m_op[7:3] == `CLS_SWAP_ACC_REG) begin
				m_t = m_acc;
				m_acc = m_reg[m_r];
				m_reg[m_r] = m_t;
			end
			m_ph = is_two(m_op);
		end else begin
			e_mc = 1'b1;
			m_t = mem[m_pc];
			m_r = {bank, m_op[2:0]};
			m_tk = cond(m_op);
			if (m_op[7:3] == `CLS_LOAD_IMM_REG)
				m_reg[m_r] = m_t;
			if (m_op[7:3] == `CLS_DEC_BRANCH_NZ) begin
				m_reg[m_r] = m_reg[m_r] - 8'h01;
				m_tk = m_reg[m_r] != 8'h00;
			end
			e_clr = m_op == `OP_BRANCH_TIMER;
			m_pc = m_tk ? {m_pc[11:8], m_t} : m_pc + 12'h001;
			m_ph = 1'b0;
		end
		s = xorshift(s);
		fl <= s[4:0];
		bank <= s[5];
	end
	initial begin
		for (i = 0; i < 4096; i++) begin
			s = xorshift(s);
			case (s[3:0])
			4'h9: mem[i] = {`CLS_LOAD_IMM_REG, s[6:4]};
			4'hA: mem[i] = {`CLS_STORE_INDIRECT, s[6:4]};
			4'hB: mem[i] = {`CLS_SWAP_ACC_REG, s[6:4]};
			4'hC: mem[i] = {`CLS_DEC_BRANCH_NZ, s[6:4]};
			4'hD, 4'hE, 4'hF: mem[i] = s[15:8];
			default: mem[i] = `OP_BRANCH_TIMER + {4'h0, s[3:0]};
			endcase
		end
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (1500) @(posedge clk_sys);
		// second reset in mid-run
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (1500) @(posedge clk_sys);
		summarize;
	end
endmodule
